// ==== pkg/window_cfg_pkg.sv ====
// constants for the downstream window configuration register bank
package window_cfg_pkg;

    // ========================================================
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int HI_W = 20;
    localparam int MASK_W = 19;

    // ========================================================
    // register byte addresses
    localparam logic [7:0] OFS_BRIDGE_EXT = 8'h94;
    localparam logic [7:0] OFS_XLAT_BASE = 8'h98;
    localparam logic [7:0] OFS_SETUP = 8'h9C;
    localparam logic [7:0] OFS_SLOT_CAP = 8'hA0;

    // ========================================================
    // field positions
    localparam int HI_LSB = 12;
    localparam int ADDR_TYPE_LSB = 1;
    localparam int PREFETCH_BIT = 3;
    localparam int ENABLE_BIT = 31;
    localparam int SLOT_LSB = 16;
    localparam int FIRST_BIT = 21;
    localparam int CHASSIS_LSB = 24;

    // ========================================================
    // reset and fixed values
    localparam logic [HI_W-1:0] BASE_RST = 20'h00000;
    localparam logic [MASK_W-1:0] MASK_RST = 19'h7FFFF;
    localparam logic [HI_W-1:0] PROBE_HI = 20'hFFFFF;
    localparam logic [1:0] ADDR_TYPE_RST = 2'h0;
    localparam logic PREFETCH_RST = 1'b0;
    localparam logic ENABLE_RST = 1'b1;
    localparam logic [7:0] SLOT_CAP_ID = 8'h04;
    localparam logic [7:0] SLOT_NEXT_PTR = 8'hB0;
    localparam logic [4:0] SLOT_RST = 5'h00;
    localparam logic FIRST_RST = 1'b0;
    localparam logic [7:0] CHASSIS_RST = 8'h00;
    localparam logic [31:0] BRIDGE_EXT_VAL = 32'h0000_0000;

    // ========================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== verilog/window_translate.sv ====
// downstream window 0 address translation stage
`timescale 1ns/1ps
`default_nettype none

module window_translate (
    input wire logic clk,
    input wire logic srst,
    input wire logic [window_cfg_pkg::HI_W-1:0] baseHi,
    input wire logic [window_cfg_pkg::HI_W-1:0] maskHi,
    input wire logic inValid,
    input wire logic [window_cfg_pkg::DATA_W-1:0] inAddr,
    output logic outValid,
    output logic [window_cfg_pkg::DATA_W-1:0] outAddr
);
    import window_cfg_pkg::*;

    logic [HI_W-1:0] mergedHi;

    // ========================================================
    // merge: significant bits come from the base, the rest pass
    assign mergedHi = (baseHi & maskHi) | (inAddr[DATA_W-1:HI_LSB] & ~maskHi);

    always_ff @(posedge clk) begin
        if (srst) begin
            outValid <= 1'b0;
            outAddr <= 32'h0000_0000;
        end else begin
            outValid <= inValid;
            if (inValid) begin
                outAddr <= {mergedHi, inAddr[HI_LSB-1:0]};
            end
        end
    end

endmodule

`default_nettype wire

// ==== verilog/downstream_window_config_regs.sv ====
// configuration registers for bridge extension, downstream window 0 and slot id
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module downstream_window_config_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic [window_cfg_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [window_cfg_pkg::DATA_W-1:0] wdata,
    input wire logic [window_cfg_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [window_cfg_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [window_cfg_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic specialSetPath,
    input wire logic [window_cfg_pkg::DATA_W-1:0] specialSetData,
    input wire logic dsValid,
    input wire logic [window_cfg_pkg::DATA_W-1:0] dsAddr,
    output logic xlatValid,
    output logic [window_cfg_pkg::DATA_W-1:0] xlatAddr,
    output logic windowEnable,
    output logic [4:0] slotNumber,
    output logic firstInChassis,
    output logic [7:0] chassisNumber
);
    import window_cfg_pkg::*;

    // ========================================================
    // write channel holding state
    logic awHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic wHeld_reg;
    logic [DATA_W-1:0] wData_reg;
    logic [STRB_W-1:0] wStrb_reg;
    logic bValid_reg;
    logic [1:0] bResp_reg;
    logic doWrite;
    logic [DATA_W-1:0] byteMask;
    logic writeMapped;

    // ========================================================
    // read channel state
    logic rValid_reg;
    logic [DATA_W-1:0] rData_reg;
    logic [1:0] rResp_reg;
    logic [DATA_W-1:0] readWord;
    logic readMapped;

    // ========================================================
    // stored fields
    logic [HI_W-1:0] base_reg;
    logic [MASK_W-1:0] sizeMask_reg;
    logic [1:0] addrType_reg;
    logic prefetch_reg;
    logic enable_reg;
    logic probe_reg;
    logic [4:0] slot_reg;
    logic first_reg;
    logic [7:0] chassis_reg;
    logic [HI_W-1:0] baseWriteMask;
    logic [HI_W-1:0] xlatMask;
    logic [DATA_W-1:0] setupWord;
    logic memSpace;
    logic [7:0] setupReserved;
    logic [1:0] slotReserved;
    logic [DATA_W-1:0] baseWord;
    logic [DATA_W-1:0] slotCapWord;

    // ========================================================
    // decoded writes and setup load fields
    logic selBase;
    logic selSetup;
    logic selSlot;
    logic [MASK_W-1:0] setMask;
    logic [1:0] setType;
    logic setPrefetch;
    logic setEnable;
    logic [1:0] writeResp;
    logic [1:0] readResp;

    // ========================================================
    // bridge support extension fields
    logic [5:0] extReserved;
    logic secondaryBusLowPowerStates;
    logic busPowerClockCtl;
    logic [7:0] extData;
    logic [DATA_W-1:0] extWord;

    // ========================================================
    // bus handshakes
    // one write buffered per channel; a new address is taken before the old response, but its write waits for it
    assign awready = !awHeld_reg;
    assign wready = !wHeld_reg;
    assign arready = !rValid_reg;
    assign bvalid = bValid_reg;
    assign bresp = bResp_reg;
    assign rvalid = rValid_reg;
    assign rdata = rData_reg;
    assign rresp = rResp_reg;

    assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;

    // ========================================================
    // write decode
    // one select per register that keeps state; the extension has none
    assign selBase = doWrite && awAddr_reg == OFS_XLAT_BASE;
    assign selSetup = doWrite && awAddr_reg == OFS_SETUP;
    assign selSlot = doWrite && awAddr_reg == OFS_SLOT_CAP;

    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
        end else if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= awaddr;
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wHeld_reg <= 1'b0;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
        end else if (doWrite) begin
            wHeld_reg <= 1'b0;
        end
    end

    always_comb begin
        unique case (awAddr_reg)
            OFS_BRIDGE_EXT,
            OFS_XLAT_BASE,
            OFS_SETUP,
            OFS_SLOT_CAP: writeMapped = 1'b1;
            default: writeMapped = 1'b0;
        endcase
    end

    // read-only bits in a mapped register still answer okay
    assign writeResp = writeMapped ? RESP_OKAY : RESP_SLVERR;

    always_ff @(posedge clk) begin
        if (srst) begin
            bValid_reg <= 1'b0;
            bResp_reg <= RESP_OKAY;
        end else if (doWrite) begin
            bValid_reg <= 1'b1;
            bResp_reg <= writeResp;
        end else if (bready) begin
            bValid_reg <= 1'b0;
        end
    end

    // ========================================================
    // byte lanes expanded to bit enables
    genvar lane;
    generate
        for (lane = 0; lane < STRB_W; lane++) begin : g_lane
            assign byteMask[8*lane +: 8] = {8{wStrb_reg[lane]}};
        end
    endgenerate

    // ========================================================
    // translated base
    // bit 31 has no mask bit of its own; the enable stands in for it
    assign baseWriteMask = {enable_reg, sizeMask_reg} & byteMask[DATA_W-1:HI_LSB];

    always_ff @(posedge clk) begin
        if (srst) begin
            base_reg <= BASE_RST;
        end else if (selBase) begin
            base_reg <= (base_reg & ~baseWriteMask) | (wData_reg[DATA_W-1:HI_LSB] & baseWriteMask);
        end
    end

    // ========================================================
    // window setup: mask, type and prefetch load only through the special set path
    // software cannot resize the window; only the load port can
    assign setMask = specialSetData[ENABLE_BIT-1:HI_LSB];
    assign setType = specialSetData[ADDR_TYPE_LSB +: 2];
    assign setPrefetch = specialSetData[PREFETCH_BIT];
    assign setEnable = specialSetData[ENABLE_BIT];

    always_ff @(posedge clk) begin
        if (srst) begin
            sizeMask_reg <= MASK_RST;
            addrType_reg <= ADDR_TYPE_RST;
            prefetch_reg <= PREFETCH_RST;
            enable_reg <= ENABLE_RST;
        end else if (specialSetPath) begin
            sizeMask_reg <= setMask;
            addrType_reg <= setType;
            prefetch_reg <= setPrefetch;
            enable_reg <= setEnable;
        end else if (selSetup && wStrb_reg[3] && !wData_reg[ENABLE_BIT]) begin
            enable_reg <= 1'b1;
        end
    end

    // a zero written to the enable turns the upper read into the 4KB probe pattern
    always_ff @(posedge clk) begin
        if (srst) begin
            probe_reg <= 1'b0;
        end else if (specialSetPath) begin
            probe_reg <= 1'b0;
        end else if (selSetup && wStrb_reg[3]) begin
            probe_reg <= !wData_reg[ENABLE_BIT];
        end
    end

    // ========================================================
    // slot identification fields
    always_ff @(posedge clk) begin
        if (srst) begin
            slot_reg <= SLOT_RST;
            first_reg <= FIRST_RST;
        end else if (selSlot && wStrb_reg[2]) begin
            slot_reg <= wData_reg[SLOT_LSB +: 5];
            first_reg <= wData_reg[FIRST_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            chassis_reg <= CHASSIS_RST;
        end else if (selSlot && wStrb_reg[3]) begin
            chassis_reg <= wData_reg[CHASSIS_LSB +: 8];
        end
    end

    // ========================================================
    // bridge support extension: nothing in it is writable
    assign extReserved = 6'h00;
    assign secondaryBusLowPowerStates = 1'b0;
    assign busPowerClockCtl = 1'b0;
    assign extData = 8'h00;
    // the low half belongs to the power management block and reads 0 here
    assign extWord = {extData, busPowerClockCtl, secondaryBusLowPowerStates, extReserved, BRIDGE_EXT_VAL[15:0]};

    // ========================================================
    // read path
    // reserved bits are tied here so that writes can never reach them
    assign memSpace = 1'b0;
    assign setupReserved = 8'h00;
    assign slotReserved = 2'b00;
    assign baseWord = {base_reg, 12'h000};
    assign slotCapWord = {chassis_reg, slotReserved, first_reg, slot_reg, SLOT_NEXT_PTR, SLOT_CAP_ID};

    always_comb begin
        setupWord = {enable_reg, sizeMask_reg, setupReserved, prefetch_reg, addrType_reg, memSpace};
        if (probe_reg) begin
            setupWord[DATA_W-1:HI_LSB] = PROBE_HI;
        end
    end

    always_comb begin
        readMapped = 1'b1;
        unique case (araddr)
            OFS_BRIDGE_EXT: readWord = extWord;
            OFS_XLAT_BASE: readWord = baseWord;
            OFS_SETUP: readWord = setupWord;
            OFS_SLOT_CAP: readWord = slotCapWord;
            default: begin
                readWord = 32'h0000_0000;
                readMapped = 1'b0;
            end
        endcase
    end

    // ========================================================
    // read response
    // unmapped reads are refused with zero data, not ignored, so a probe cannot hang
    assign readResp = readMapped ? RESP_OKAY : RESP_SLVERR;

    always_ff @(posedge clk) begin
        if (srst) begin
            rValid_reg <= 1'b0;
            rData_reg <= 32'h0000_0000;
            rResp_reg <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rValid_reg <= 1'b1;
            rData_reg <= readWord;
            rResp_reg <= readResp;
        end else if (rready) begin
            rValid_reg <= 1'b0;
        end
    end

    // ========================================================
    // translation datapath
    // the mask is read live: a resize applies to the next address offered
    assign xlatMask = {enable_reg, sizeMask_reg};

    window_translate u_translate (
        .clk(clk),
        .srst(srst),
        .baseHi(base_reg),
        .maskHi(xlatMask),
        .inValid(dsValid),
        .inAddr(dsAddr),
        .outValid(xlatValid),
        .outAddr(xlatAddr)
    );

    // ========================================================
    // field outputs for the rest of the bridge
    assign windowEnable = enable_reg;
    assign slotNumber = slot_reg;
    assign firstInChassis = first_reg;
    assign chassisNumber = chassis_reg;

endmodule

`default_nettype wire

// ==== bench/host_model.sv ====
// host bus master model for the window configuration registers
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input wire logic clk,
    output logic [7:0] awaddr = 8'h00,
    output logic [2:0] awprot = 3'h0,
    output logic awvalid = 1'b0,
    input wire logic awready,
    output logic [31:0] wdata = 32'h0,
    output logic [3:0] wstrb = 4'h0,
    output logic wvalid = 1'b0,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready = 1'b0,
    output logic [7:0] araddr = 8'h00,
    output logic [2:0] arprot = 3'h0,
    output logic arvalid = 1'b0,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready = 1'b0
);
    int hangs = 0;

    // ========================================
    // bus tasks
    // ready is read at the falling edge: it cannot move before the next rise
    task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        bit aw;
        bit w;
        bit b = 1'b0;
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64 && !b; n++) begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (w) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        bready <= 1'b0;
        hangs += int'(!b);
    endtask

    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar;
        bit got = 1'b0;
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64 && !got; n++) begin
            @(negedge clk);
            ar = arvalid && arready;
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end
        rready <= 1'b0;
        hangs += int'(!got);
    endtask
endmodule
`default_nettype wire

// ==== bench/window_cfg_asserts.sv ====
// port checker for the window configuration registers
`timescale 1ns/1ps
`default_nettype none

module window_cfg_asserts
    import window_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [window_cfg_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [window_cfg_pkg::DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic specialSetPath,
    input wire logic windowEnable,
    input wire logic dsValid,
    input wire logic [window_cfg_pkg::DATA_W-1:0] dsAddr,
    input wire logic xlatValid,
    input wire logic [window_cfg_pkg::DATA_W-1:0] xlatAddr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [7:0] lastAr;
    logic [11:0] lowPast;

    // ========================================
    // helpers
    always_ff @(posedge clk) begin
        if (arvalid && arready) begin
            lastAr <= araddr;
        end
    end
    always_ff @(posedge clk) begin
        lowPast <= dsAddr[11:0];
    end

    // ========================================
    // assertions
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready) else $error("read not answered");
    a_write_answer: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##[1:2] bvalid)
        else $error("write not answered");
    a_ext_zero: assert property ($rose(rvalid) && lastAr == OFS_BRIDGE_EXT |-> rdata == 32'h0)
        else $error("bridge extension not zero");
    a_cap_fixed: assert property ($rose(rvalid) && lastAr == OFS_SLOT_CAP |->
        rdata[15:0] == 16'hB004 && rdata[23:22] == 2'h0) else $error("slot capability fixed bits wrong");
    a_setup_fixed: assert property ($rose(rvalid) && lastAr == OFS_SETUP |->
        rdata[0] == 1'b0 && rdata[11:4] == 8'h00) else $error("setup fixed bits wrong");
    a_enable_kept: assert property (windowEnable && !specialSetPath |=> windowEnable)
        else $error("enable dropped");
    a_xlat_low: assert property (dsValid |=> xlatValid && xlatAddr[11:0] == lowPast)
        else $error("translation low bits wrong");
    a_unmapped_read: assert property ($rose(rvalid) && !(lastAr inside {8'h94, 8'h98, 8'h9C, 8'hA0}) |->
        rresp == RESP_SLVERR && rdata == 32'h0) else $error("unmapped read not refused");

    c_read: cover property (rvalid && lastAr == OFS_SLOT_CAP);
    c_write: cover property (bvalid);
    c_xlat: cover property (xlatValid);
endmodule

bind downstream_window_config_regs window_cfg_asserts window_cfg_asserts_i (.clk, .srst, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .specialSetPath,
    .windowEnable, .dsValid, .dsAddr, .xlatValid, .xlatAddr);
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the window configuration registers
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import window_cfg_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awaddr, araddr, chassisNumber;
    logic [2:0] awprot, arprot;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, xlatAddr, got;
    logic [31:0] specialSetData = 32'h0;
    logic [31:0] dsAddr = 32'h0;
    logic specialSetPath = 1'b0;
    logic dsValid = 1'b0;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic xlatValid, windowEnable, firstInChassis;
    logic [4:0] slotNumber;
    int fail_count = 0;
    int num_checks = 0;

    always #4 clk = ~clk;

    downstream_window_config_regs downstream_window_config_regs_i (.clk, .srst, .awaddr, .awprot, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .specialSetPath, .specialSetData, .dsValid, .dsAddr,
        .xlatValid, .xlatAddr, .windowEnable, .slotNumber, .firstInChassis, .chassisNumber);
    host_model host_model_i (.clk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    // ========================================
    // checking tasks
    task automatic tally_and_finish();
        fail_count += host_model_i.hangs;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // a hung handshake ends the run at once
    task automatic resp_check(input logic [1:0] er);
        check({30'h0, resp}, {30'h0, er});
        if (host_model_i.hangs != 0) begin
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er = 2'h0);
        host_model_i.write(a, d, s, resp);
        resp_check(er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        host_model_i.read(a, got, resp);
        resp_check(er);
        check(got, e);
    endtask

    // ========================================
    // sequence
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(8'h94, 32'h0);
        rd(8'h98, 32'h0);
        rd(8'h9C, 32'hFFFFF000);
        rd(8'hA0, 32'h0000B004);
        wr(8'h94, 32'hFFFFFFFF, 4'hF);
        rd(8'h94, 32'h0);
        wr(8'h9C, 32'h8000000F, 4'hF);
        rd(8'h9C, 32'hFFFFF000);
        wr(8'h98, 32'hFFFFFFFF, 4'hF);
        rd(8'h98, 32'hFFFFF000);
        wr(8'h98, 32'h0, 4'h8);
        rd(8'h98, 32'h00FFF000);
        // narrow to the top byte, 64-bit prefetchable
        @(posedge clk);
        specialSetData <= 32'hFF00000A;
        specialSetPath <= 1'b1;
        @(posedge clk);
        specialSetPath <= 1'b0;
        rd(8'h9C, 32'hFF00000A);
        @(posedge clk);
        dsAddr <= 32'h12345678;
        dsValid <= 1'b1;
        @(posedge clk);
        dsValid <= 1'b0;
        @(negedge clk);
        check({31'h0, xlatValid}, 32'h1);
        check(xlatAddr, 32'h00345678);
        wr(8'h98, 32'hFFFFFFFF, 4'hF);
        rd(8'h98, 32'hFFFFF000);
        wr(8'h98, 32'h0, 4'hF);
        rd(8'h98, 32'h00FFF000);
        wr(8'h9C, 32'h0, 4'hF);
        rd(8'h9C, 32'hFFFFF00A);
        check({31'h0, windowEnable}, 32'h1);
        wr(8'h9C, 32'h80000000, 4'h8);
        rd(8'h9C, 32'hFF00000A);
        wr(8'hA0, 32'hFFFFFFFF, 4'hF);
        rd(8'hA0, 32'hFF3FB004);
        check({19'h0, chassisNumber, slotNumber}, {19'h0, 8'hFF, 5'h1F});
        wr(8'hA0, 32'h5A150000, 4'h4);
        rd(8'hA0, 32'hFF15B004);
        check({31'h0, firstInChassis}, 32'h0);
        wr(8'h10, 32'h1234, 4'hF, RESP_SLVERR);
        rd(8'hA4, 32'h0, RESP_SLVERR);
        rd(8'hA0, 32'hFF15B004);
        tally_and_finish();
    end
endmodule
`default_nettype wire
